/* File: src/watchdog_pkg.sv */
package watchdog_pkg;
	// apb register map (byte addresses)
	localparam logic [7:0] wdt_control_addr = 8'h00;
	localparam logic [7:0] wdt_status_addr = 8'h04;
	localparam logic [7:0] irq_status_addr = 8'h08;
	localparam logic [7:0] irq_mask_addr = 8'h0c;
	localparam logic [7:0] reload_addr = 8'h10;
	localparam logic [7:0] count_addr = 8'h14;
	// control register fields
	localparam int lock_hi_pos = 7;
	localparam int lock_lo_pos = 5;
	localparam int src_osc_pos = 7;
	localparam int src_div_pos = 6;
	localparam int stop_fn_pos = 5;
	localparam logic [7:0] control_reset = 8'h00;
	// interrupt status bits
	localparam int irq_underflow_pos = 0;
	localparam int irq_lock_viol_pos = 1;
	localparam int irq_flash_clear_pos = 2;
	localparam int irq_width = 3;
	localparam logic [irq_width-1:0] irq_reset = 3'h0;
	// counter
	localparam int count_width = 16;
	localparam logic [count_width-1:0] reload_reset = 16'hffff;
	localparam logic [7:0] prescale_div = 8'h10;
	localparam logic [7:0] slow_div = 8'h08;
	// internal reset pulse length
	localparam int reset_pulse_ns = 64;
	localparam int clock_period_ns = 8;
	localparam logic [3:0] reset_pulse_cycles = 4'((reset_pulse_ns + clock_period_ns - 1)
		/ clock_period_ns);
	// boot vector addresses
	localparam logic [15:0] boot_vector_lo = 16'hfffc;
	localparam logic [15:0] boot_vector_hi = 16'hfffd;
	localparam logic [15:0] user_vector_lo = 16'hfffc;
	typedef enum logic [2:0] {
		st_run = 3'b001,
		st_stopped = 3'b010,
		st_reset_out = 3'b100
	} wdt_state_e;
endpackage

/* File: src/tick_divider.sv */
`timescale 1ns/1ns
module tick_divider (
	input wire logic clock, // system clock
	input wire logic reset, // sync reset
	input wire logic enable, // count when high
	input wire logic [7:0] divisor, // ticks every divisor enables
	output logic tick // one-cycle enable pulse
);
	logic [7:0] count;

	always_ff @(posedge clock) begin
		if (reset) begin
			count <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (enable) begin
				if (count >= divisor - 8'h01) begin
					count <= 8'h00;
					tick <= 1'b1;
				end else begin
					count <= count + 8'h01;
				end
			end
		end
	end
endmodule

/* File: src/watchdog_timer.sv */
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
module watchdog_timer (
	input wire logic clock, // 125 mhz system clock
	input wire logic reset, // sync active high
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic stop_mode, // device in stop mode
	input wire logic wait_mode, // device in wait mode
	input wire logic settle_wait, // stop-release settling in progress
	input wire logic osc_stop_request, // request to stop on-chip oscillator
	input wire logic flash_busy, // flash program or erase running
	input wire logic boot_mode_select_pin, // boot pin, asynchronous
	output logic osc_run, // on-chip oscillator enable
	output logic internal_reset, // watchdog reset to device
	output logic boot_mode, // boot mode latched at reset release
	output logic [15:0] start_vector_addr, // address of start vector low byte
	output logic irq // level interrupt
);
	import watchdog_pkg::*;

	wdt_state_e state;
	logic [7:0] control;
	logic locked;
	logic [count_width-1:0] reload;
	logic [count_width-1:0] count;
	logic [irq_width-1:0] irq_status;
	logic [irq_width-1:0] irq_mask;
	logic [3:0] pulse_count;
	logic boot_meta;
	logic boot_sync;
	logic reset_seen;
	logic src_enable;
	logic tick;
	logic access;
	logic wr;
	logic control_write;
	logic underflow;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic [irq_width-1:0] events;

	function automatic logic mapped(input logic [7:0] a);
		return a == wdt_control_addr || a == wdt_status_addr || a == irq_status_addr
			|| a == irq_mask_addr || a == reload_addr || a == count_addr;
	endfunction

	assign access = psel && penable && pready;
	assign wr = access && pwrite && mapped(paddr);
	assign control_write = wr && paddr == wdt_control_addr;
	// counting runs in run state only; wait and settle do not gate it
	assign src_enable = state == st_run && !flash_busy;
	assign underflow = tick && count == '0 && !flash_busy;

	tick_divider prescaler (
		.clock(clock),
		.reset(reset),
		.enable(src_enable),
		.divisor(control[src_div_pos] ? slow_div : prescale_div),
		.tick(tick)
	);

	// apb: one wait state, so pready rises in the first access cycle's next edge
	always_ff @(posedge clock) begin
		if (reset) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	always_comb begin
		next_prdata = 32'h00000000;
		next_pslverr = 1'b0;
		unique case (paddr)
			wdt_control_addr: next_prdata = {24'h000000, control};
			wdt_status_addr: next_prdata = {28'h0000000, boot_mode, flash_busy, osc_run,
				locked};
			irq_status_addr: next_prdata = {29'h00000000, irq_status};
			irq_mask_addr: next_prdata = {29'h00000000, irq_mask};
			reload_addr: next_prdata = {16'h0000, reload};
			count_addr: next_prdata = {16'h0000, count};
			default: next_pslverr = 1'b1;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			prdata <= pwrite ? 32'h00000000 : next_prdata;
			pslverr <= next_pslverr;
		end else begin
			// error stands only beside the one-cycle ready; read data is held
			pslverr <= 1'b0;
		end
	end

	// write-once upper control bits
	always_ff @(posedge clock) begin
		if (reset) begin
			control <= control_reset;
			locked <= 1'b0;
		end else if (control_write) begin
			control[lock_lo_pos-1:0] <= pwdata[lock_lo_pos-1:0];
			if (!locked) begin
				control[lock_hi_pos:lock_lo_pos] <= pwdata[lock_hi_pos:lock_lo_pos];
				locked <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			reload <= reload_reset;
		end else if (wr && paddr == reload_addr) begin
			reload <= pwdata[count_width-1:0];
		end
	end

	// oscillator cannot be stopped while it is the count source
	always_ff @(posedge clock) begin
		if (reset) begin
			osc_run <= 1'b1;
		end else begin
			osc_run <= control[src_osc_pos] || !osc_stop_request;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= st_run;
		end else begin
			unique case (state)
				st_run: begin
					if (underflow) begin
						state <= st_reset_out;
					end else if (stop_mode && !settle_wait) begin
						state <= st_stopped;
					end
				end
				st_stopped: begin
					if (!stop_mode || settle_wait) begin
						state <= st_run;
					end
				end
				st_reset_out: begin
					if (pulse_count == 4'h1) begin
						state <= st_run;
					end
				end
				default: state <= st_run;
			endcase
		end
	end

	// counter: stop mode with settle_wait low freezes it since the prescaler gets no enable
	always_ff @(posedge clock) begin
		if (reset) begin
			count <= reload_reset;
		end else if (flash_busy) begin
			count <= reload;
		end else if (control_write) begin
			count <= reload;
		end else if (state == st_reset_out) begin
			count <= reload;
		end else if (tick && count != '0) begin
			count <= count - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			internal_reset <= 1'b0;
			pulse_count <= 4'h0;
		end else if (underflow && state == st_run) begin
			internal_reset <= 1'b1;
			pulse_count <= reset_pulse_cycles;
		end else if (pulse_count != 4'h0) begin
			pulse_count <= pulse_count - 4'h1;
			internal_reset <= pulse_count != 4'h1;
		end
	end

	// boot pin is caught on the first clock after reset release
	always_ff @(posedge clock) begin
		boot_meta <= boot_mode_select_pin;
		boot_sync <= boot_meta;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			reset_seen <= 1'b0;
			boot_mode <= 1'b0;
			start_vector_addr <= user_vector_lo;
		end else if (!reset_seen) begin
			reset_seen <= 1'b1;
			boot_mode <= boot_sync;
			start_vector_addr <= boot_sync ? boot_vector_lo : user_vector_lo;
		end
	end

	assign events[irq_underflow_pos] = underflow && state == st_run;
	assign events[irq_lock_viol_pos] = control_write && locked;
	assign events[irq_flash_clear_pos] = flash_busy && count != reload;

	// set wins over a simultaneous write-one clear
	always_ff @(posedge clock) begin
		if (reset) begin
			irq_status <= irq_reset;
			irq_mask <= irq_reset;
			irq <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~((wr && paddr == irq_status_addr) ?
				pwdata[irq_width-1:0] : irq_reset)) | events;
			if (wr && paddr == irq_mask_addr) begin
				irq_mask <= pwdata[irq_width-1:0];
			end
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule

/* File: tb/wdt_monitor.sv */
`timescale 1ns/1ns
module wdt_monitor
	import watchdog_pkg::*;
(
	input wire logic clock, // clk
	input wire logic reset, // rst
	input wire logic psel, // apb
	input wire logic penable, // apb
	input wire logic pwrite, // apb
	input wire logic [7:0] paddr, // apb
	input wire logic [31:0] pwdata, // apb
	input wire logic pready, // apb
	input wire logic pslverr, // apb
	input wire logic stop_mode, // mode
	input wire logic settle_wait, // mode
	input wire logic flash_busy, // flash
	input wire logic osc_run, // osc
	input wire logic internal_reset, // out
	input wire logic boot_mode, // out
	input wire logic [15:0] start_vector_addr // out
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	logic osc_sel;
	logic seen;
	// first control write is the one that sticks
	always_ff @(posedge clock) begin
		if (reset) begin
			osc_sel <= 1'b0;
			seen <= 1'b0;
		end else if (psel && penable && pready && pwrite && paddr == wdt_control_addr && !seen) begin
			osc_sel <= pwdata[src_osc_pos];
			seen <= 1'b1;
		end
	end
	sequence acc_start;
		psel && $rose(penable);
	endsequence
	sequence pulse8;
		internal_reset[*8] ##1 !internal_reset;
	endsequence
	AST_ANSWER: assert property (acc_start |=> pready) else $error("late answer");
	AST_ONE: assert property (pready |=> !pready) else $error("long ready");
	AST_ERR: assert property (pslverr |-> pready) else $error("stray error");
	AST_STOP_HOLD: assert property ((stop_mode && !settle_wait)[*3] |-> !$rose(internal_reset))
		else $error("reset in stop");
	AST_FLASH: assert property (flash_busy[*3] |-> !$rose(internal_reset))
		else $error("reset in flash");
	AST_RST_LEN: assert property ($rose(internal_reset) |-> pulse8)
		else $error("pulse length");
	AST_OSC: assert property (osc_sel && $past(osc_sel) |-> osc_run)
		else $error("osc stopped");
	AST_BOOT_HOLD: assert property (!reset[*3] |-> $stable(boot_mode))
		else $error("boot moved");
	AST_VEC: assert property (!$past(reset) |-> start_vector_addr == boot_vector_lo)
		else $error("bad vector");
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
	import watchdog_pkg::*;
	logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, a, m_ctrl;
	logic pready, pslverr, stop_mode = 0, wait_mode = 0, settle_wait = 0;
	logic osc_stop_request = 0, flash_busy = 0, boot_mode_select_pin = 0;
	logic osc_run, internal_reset, boot_mode, irq;
	logic [15:0] start_vector_addr;
	int fails = 0, n_compared = 0, rst_cnt = 0;
	always #4 clock = ~clock;
	always @(posedge clock) if (internal_reset === 1'b1) rst_cnt++;
	watchdog_timer dut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .stop_mode, .wait_mode, .settle_wait, .osc_stop_request,
		.flash_busy, .boot_mode_select_pin, .osc_run, .internal_reset, .boot_mode,
		.start_vector_addr, .irq);
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		// values read right after the edge are those the design sampled there
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rchk(input logic [7:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(rd, exp);
	endtask
	task do_reset(input logic pin);
		@(posedge clock);
		boot_mode_select_pin <= pin;
		reset <= 1'b1;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
	endtask
	task close_out;
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		void'($urandom(23));
		do_reset(1'b0);
		rchk(wdt_control_addr, 32'h0);
		rchk(reload_addr, 32'hffff);
		rchk(wdt_status_addr, 32'h2);
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1);
		$display("reset values done");
		m_ctrl = 32'ha0 | ($urandom & 32'h1f);
		osc_stop_request <= 1'b1;
		apb(1'b1, wdt_control_addr, m_ctrl);
		apb(1'b1, wdt_control_addr, 32'h7f);
		m_ctrl = (m_ctrl & 32'he0) | 32'h1f;
		rchk(wdt_control_addr, m_ctrl);
		rchk(irq_status_addr, 32'h2);
		chk(osc_run, 1'b1);
		apb(1'b1, irq_mask_addr, 32'h3);
		repeat (2) @(posedge clock);
		chk(irq, 1'b1);
		apb(1'b1, irq_status_addr, 32'h2);
		repeat (2) @(posedge clock);
		chk(irq, 1'b0);
		$display("lock and irq done");
		for (int i = 0; i < 3; i++) begin
			stop_mode <= i < 2;
			settle_wait <= i == 1;
			wait_mode <= i == 2;
			apb(1'b1, wdt_control_addr, m_ctrl);
			apb(1'b0, count_addr, 32'h0);
			a = rd;
			repeat (40) @(posedge clock);
			apb(1'b0, count_addr, 32'h0);
			if (i == 0) chk(rd, a);
			else chk(rd < a, 1'b1);
		end
		stop_mode <= 1'b0;
		$display("modes done");
		flash_busy <= 1'b1;
		apb(1'b1, reload_addr, 32'h3);
		rst_cnt = 0;
		repeat (200) @(posedge clock);
		rchk(count_addr, 32'h3);
		chk(rst_cnt, 0);
		flash_busy <= 1'b0;
		apb(1'b1, wdt_control_addr, m_ctrl);
		rst_cnt = 0;
		repeat (100) @(posedge clock);
		chk(rst_cnt, 8);
		apb(1'b0, irq_status_addr, 32'h0);
		chk(rd[irq_underflow_pos], 1'b1);
		$display("flash and underflow done");
		do_reset(1'b1);
		repeat (4) @(posedge clock);
		chk(boot_mode, 1'b1);
		chk(start_vector_addr, boot_vector_lo);
		rchk(wdt_control_addr, 32'h0);
		apb(1'b1, wdt_control_addr, 32'h40);
		rchk(wdt_control_addr, 32'h40);
		chk(osc_run, 1'b0);
		$display("boot reset done");
		close_out;
	end
	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		close_out;
	end
endmodule
bind watchdog_timer wdt_monitor mon (.clock, .reset, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .stop_mode, .settle_wait, .flash_busy, .osc_run,
	.internal_reset, .boot_mode, .start_vector_addr);
